// ---- design/kid_pkg.sv ----
// package: register map, field positions and bus carriers for the key interrupt detector
package kid_pkg;

  localparam int          KID_ADDR_W          = 20;
  localparam int          KID_DATA_W          = 32;
  localparam int          KID_NKEY            = 6;
  localparam int          KID_NEV             = 2;

  // byte addresses, one aligned word each
  localparam logic [19:0] KID_OFS_KEY_CONTROL = 20'hf_ff34;
  localparam logic [19:0] KID_OFS_KEY_ENABLE  = 20'hf_ff38;
  localparam logic [19:0] KID_OFS_KEY_FLAGS   = 20'hf_ff3c;
  localparam logic [19:0] KID_OFS_IRQ_STATUS  = 20'hf_ff40;
  localparam logic [19:0] KID_OFS_IRQ_CLEAR   = 20'hf_ff44;
  localparam logic [19:0] KID_OFS_IRQ_ENABLE  = 20'hf_ff48;

  // key_control fields
  localparam int          KID_CTRL_FLAG_USE   = 7;
  localparam int          KID_CTRL_EDGE_POL   = 0;

  // interrupt status bits
  localparam int          KID_EV_KEY_REQ      = 0;
  localparam int          KID_EV_FLAG_LOAD    = 1;

  // values after reset
  localparam logic [7:0]  KID_RST_BYTE        = 8'h00;
  localparam logic [5:0]  KID_RST_KEYS        = 6'h00;
  // key pins idle high behind their pull-ups
  localparam logic [5:0]  KID_KEY_IDLE        = 6'h3f;
  localparam logic [1:0]  KID_RST_EV          = 2'h0;
  localparam logic [31:0] KID_RST_WORD        = 32'h0000_0000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [19:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } kid_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } kid_apb_rsp_t;

endpackage : kid_pkg

// ---- design/kid_key_irq.sv ----
// key interrupt detector: six key inputs, edge flags, apb registers, interrupt output
// Notes on behaviour
// RL1 - six keys, own enable and flag, one request
// RL2 - reset clears control, enable and flag registers
// RL3 - registers take bit and byte writes; here lane zero byte writes only, single bits by read-modify-write
// RL4 - flag-usage bit selects latched flag mode
// RL5 - polarity bit: zero falling, one rising, all keys
// RL6 - level request without flags, flags identify otherwise
// RL7 - only enabled keys take part in detection
// RL8 - enabling at active level raises a request
// RL9 - software masks, enables, clears pending, unmasks
// RL10 - flag write: one ignored, zero clears
// RL11 - software leaves flags alone while unused
// RL12 - software sets pin input and digital mode
// RL13 - no flags: request follows active input levels
// RL14 - flags: request held until flag cleared
// RL15 - flags: exactly one request per valid edge; here edges seen in one cycle or queued together share one request
// RL16 - queued edge flags after clear, request next clock
// RL17 - keys synchronised before edge detection
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps

module kid_key_irq (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clk_en,
  input  wire kid_pkg::kid_apb_req_t apb_req,
  output kid_pkg::kid_apb_rsp_t    apb_rsp,
  input  wire logic [5:0]          key_in,
  output logic                     key_irq,
  output logic                     irq
);
  import kid_pkg::*;

  // keys that sit at the level the polarity calls active
  function automatic logic [5:0] level_match(input logic pol, input logic [5:0] lvl);
    level_match = pol ? lvl : ~lvl;
  endfunction : level_match

  // byte lane zero write, upper lanes ignored
  function automatic logic [7:0] lane_write(input logic [7:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    lane_write = strb[0] ? wd[7:0] : old;
  endfunction : lane_write

  logic [5:0]  key_meta;
  logic [5:0]  key_sync;
  logic [5:0]  key_prev;
  logic [5:0]  en_prev;
  logic [7:0]  key_control;
  logic [7:0]  key_channel_enable;
  logic [5:0]  key_edge_flags;
  logic [5:0]  edge_pend;
  logic [1:0]  irq_status;
  logic [1:0]  irq_enable;
  logic [31:0] rdata;
  logic        slverr;

  logic        flag_usage_select;
  logic        edge_polarity_select;
  logic [5:0]  chan_en;
  logic [5:0]  active_lvl;
  logic [5:0]  edge_hit;
  logic        flags_empty;
  logic        flag_load;
  logic        next_key_irq;
  logic [1:0]  next_irq_status;
  logic        setup;
  logic        access;
  logic        wr;
  logic        sel_ctrl;
  logic        sel_en;
  logic        sel_flags;
  logic        sel_stat;
  logic        sel_clr;
  logic        sel_ien;
  logic        hit;
  logic [31:0] next_rdata;

  assign flag_usage_select    = key_control[KID_CTRL_FLAG_USE];  // see RL4
  assign edge_polarity_select = key_control[KID_CTRL_EDGE_POL];  // see RL5
  assign chan_en              = key_channel_enable[5:0];

  // ---------------- key sampling ----------------
  // two stages before any logic looks at a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // reset to the idle pin level, so leaving reset shows no false edge
      key_meta <= KID_KEY_IDLE;
      key_sync <= KID_KEY_IDLE;
    end else if (clk_en) begin
      key_meta <= key_in;                                        // see RL17
      key_sync <= key_meta;                                      // see RL17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_prev <= KID_KEY_IDLE;
      en_prev  <= KID_RST_KEYS;
    end else if (clk_en) begin
      key_prev <= key_sync;
      en_prev  <= chan_en;
    end
  end

  // disabled keys stay plain port pins
  assign active_lvl = level_match(edge_polarity_select, key_sync) & chan_en;  // see RL7

  // a fresh enable on a key already at its active level counts as an edge
  assign edge_hit = (chan_en & level_match(edge_polarity_select, key_sync)
                     & ~level_match(edge_polarity_select, key_prev))          // see RL5
                  | (chan_en & ~en_prev & active_lvl);                        // see RL8

  // ---------------- apb decode ----------------
  assign setup  = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable;
  assign wr     = access & apb_req.pwrite;

  always_comb begin
    sel_ctrl  = 1'b0;
    sel_en    = 1'b0;
    sel_flags = 1'b0;
    sel_stat  = 1'b0;
    sel_clr   = 1'b0;
    sel_ien   = 1'b0;
    if (apb_req.paddr == KID_OFS_KEY_CONTROL) begin
      sel_ctrl = 1'b1;
    end else if (apb_req.paddr == KID_OFS_KEY_ENABLE) begin
      sel_en = 1'b1;
    end else if (apb_req.paddr == KID_OFS_KEY_FLAGS) begin
      sel_flags = 1'b1;
    end else if (apb_req.paddr == KID_OFS_IRQ_STATUS) begin
      sel_stat = 1'b1;
    end else if (apb_req.paddr == KID_OFS_IRQ_CLEAR) begin
      sel_clr = 1'b1;
    end else if (apb_req.paddr == KID_OFS_IRQ_ENABLE) begin
      sel_ien = 1'b1;
    end
  end

  assign hit = sel_ctrl | sel_en | sel_flags | sel_stat | sel_clr | sel_ien;

  always_comb begin
    next_rdata = KID_RST_WORD;
    if (sel_ctrl) begin
      next_rdata[7:0] = key_control;
    end else if (sel_en) begin
      next_rdata[7:0] = key_channel_enable;
    end else if (sel_flags) begin
      next_rdata[5:0] = key_edge_flags;
    end else if (sel_stat) begin
      next_rdata[1:0] = irq_status;
    end else if (sel_ien) begin
      next_rdata[1:0] = irq_enable;
    end
  end

  // read data and error are set up one cycle ahead, so the slave never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata  <= KID_RST_WORD;
      slverr <= 1'b0;
    end else if (clk_en && setup) begin
      rdata  <= apb_req.pwrite ? KID_RST_WORD : next_rdata;
      slverr <= ~hit;
    end
  end

  assign apb_rsp = '{prdata:  rdata,
                     pready:  1'b1,
                     pslverr: access & slverr};

  // ---------------- control registers ----------------
  // single bits change through read-modify-write of lane zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_control <= KID_RST_BYTE;                               // see RL2
    end else if (clk_en && wr && sel_ctrl) begin
      key_control <= lane_write(key_control, apb_req.pwdata, apb_req.pstrb);  // see RL3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_channel_enable <= KID_RST_BYTE;                        // see RL2
    end else if (clk_en && wr && sel_en) begin
      key_channel_enable <= lane_write(key_channel_enable, apb_req.pwdata,
                                       apb_req.pstrb) & 8'h3f;                // see RL1
    end
  end

  // ---------------- edge flags ----------------
  // flags load only when all are clear; edges seen meanwhile wait in edge_pend
  assign flags_empty = (key_edge_flags == KID_RST_KEYS);
  assign flag_load   = flag_usage_select & flags_empty & ((edge_pend | edge_hit) != KID_RST_KEYS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_edge_flags <= KID_RST_KEYS;                            // see RL2
    end else if (clk_en) begin
      if (!flag_usage_select) begin
        key_edge_flags <= KID_RST_KEYS;                          // see RL11
      end else if (flags_empty) begin
        key_edge_flags <= edge_pend | edge_hit;                  // see RL16
      end else if (wr && sel_flags && apb_req.pstrb[0]) begin
        key_edge_flags <= key_edge_flags & apb_req.pwdata[5:0];  // see RL10
      end
    end
  end

  // an edge in the cycle of a clear is queued, never dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_pend <= KID_RST_KEYS;
    end else if (clk_en) begin
      if (!flag_usage_select || flags_empty) begin
        edge_pend <= KID_RST_KEYS;
      end else begin
        edge_pend <= edge_pend | edge_hit;                       // see RL15
      end
    end
  end

  // ---------------- key request ----------------
  assign next_key_irq = flag_usage_select ? !flags_empty       // see RL14
                                          : (active_lvl != KID_RST_KEYS);  // see RL13

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_irq <= 1'b0;
    end else if (clk_en) begin
      key_irq <= next_key_irq;                                   // see RL6
    end
  end

  // ---------------- interrupt status ----------------
  always_comb begin
    next_irq_status = irq_status;
    if (wr && sel_clr && apb_req.pstrb[0]) begin
      next_irq_status = irq_status & ~apb_req.pwdata[1:0];       // see RL9
    end
    next_irq_status[KID_EV_KEY_REQ]   = next_irq_status[KID_EV_KEY_REQ] | (next_key_irq & ~key_irq);
    next_irq_status[KID_EV_FLAG_LOAD] = next_irq_status[KID_EV_FLAG_LOAD] | flag_load;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= KID_RST_EV;
    end else if (clk_en) begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= KID_RST_EV;
    end else if (clk_en && wr && sel_ien && apb_req.pstrb[0]) begin
      irq_enable <= apb_req.pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(next_irq_status & irq_enable);
    end
  end

  // ---------------- checks ----------------
  default clocking kid_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  reset_clear_a: assert property ($rose(presetn) |->           // see RL2
      key_control == KID_RST_BYTE && key_channel_enable == KID_RST_BYTE
      && key_edge_flags == KID_RST_KEYS && !key_irq)
    else $error("registers not cleared by reset");

  level_follow_a: assert property (clk_en && !flag_usage_select  // see RL13
      && (active_lvl != KID_RST_KEYS) |=> key_irq)
    else $error("key request missing while key held active");

  level_drop_a: assert property (clk_en && !flag_usage_select    // see RL6
      && (active_lvl == KID_RST_KEYS) |=> !key_irq)
    else $error("key request without active key");

  flag_hold_a: assert property (clk_en && flag_usage_select      // see RL14
      && !flags_empty |=> key_irq)
    else $error("key request dropped while flag pending");

  one_write_a: assert property (clk_en && wr && sel_flags        // see RL10
      && apb_req.pwdata[5:0] == 6'h3f |=>
      (key_edge_flags & $past(key_edge_flags)) == $past(key_edge_flags))
    else $error("writing one altered a flag");

  zero_clear_a: assert property (clk_en && flag_usage_select && !flags_empty  // see RL10
      && wr && sel_flags && apb_req.pstrb[0] |=>
      (key_edge_flags & ~$past(apb_req.pwdata[5:0])) == KID_RST_KEYS)
    else $error("flag not cleared by zero");

  queued_load_a: assert property (clk_en && flag_usage_select && flags_empty  // see RL16
      && edge_pend != KID_RST_KEYS |=> key_edge_flags == $past(edge_pend | edge_hit))
    else $error("queued edge not moved into flags");

  disabled_key_a: assert property ((edge_hit & ~chan_en) == KID_RST_KEYS)  // see RL7
    else $error("edge seen on disabled key");

  edge_level_a: assert property ((edge_hit                       // see RL5
      & ~level_match(edge_polarity_select, key_sync)) == KID_RST_KEYS)
    else $error("edge taken at inactive level");

  enable_req_a: assert property (clk_en && !flag_usage_select    // see RL8
      && (chan_en & ~en_prev & active_lvl) != KID_RST_KEYS |=> key_irq)
    else $error("no request when key enabled at active level");

  flag_set_a: assert property (clk_en && flag_usage_select && flags_empty  // see RL15
      && edge_hit != KID_RST_KEYS |=>
      (key_edge_flags & $past(edge_hit)) == $past(edge_hit))
    else $error("valid edge did not set its flag");

  pend_hold_a: assert property (clk_en && flag_usage_select && !flags_empty  // see RL16
      && edge_hit != KID_RST_KEYS |=>
      (edge_pend & $past(edge_hit)) == $past(edge_hit))
    else $error("edge lost while a flag was pending");

  flags_unused_a: assert property (clk_en && !flag_usage_select  // see RL4
      |=> key_edge_flags == KID_RST_KEYS)
    else $error("flag held while flags unused");

  // status is sticky, so an enabled bit keeps the line up until cleared or masked
  irq_level_a: assert property (clk_en && (irq_status & irq_enable) != KID_RST_EV  // see RL6
      && !(wr && sel_clr) && !(wr && sel_ien) |=> irq)
    else $error("interrupt low while enabled status set");

  cover_level_req: cover property (clk_en && !flag_usage_select ##1 $rose(key_irq));
  cover_flag_req: cover property (clk_en && flag_load ##1 key_irq);
  cover_queued: cover property (clk_en && flags_empty && edge_pend != KID_RST_KEYS);
  cover_irq_out: cover property ($rose(irq));

endmodule : kid_key_irq

// ---- verification/kid_key_model.sv ----
// model of the key pins: switches to ground with pull-ups
`timescale 1ns/100ps

module kid_key_model (
  input  wire logic [5:0] press,
  output wire logic [5:0] key_in
);
  // released keys float to the pull-up level, pressed keys pull low
  // pins move off the clock edge, as real switches do
  // pins reach the block as plain digital inputs
  assign #7 key_in = ~press;

endmodule : kid_key_model

// ---- verification/kid_key_irq_tb.sv ----
// self-checking bench for the key interrupt detector
`timescale 1ns/100ps

module kid_key_irq_tb;
  import kid_pkg::*;

  logic         pclk;
  logic         presetn;
  logic         clk_en;
  kid_apb_req_t req;
  kid_apb_rsp_t apb_rsp;
  logic [5:0]   press;
  logic [5:0]   key_in;
  logic         key_irq;
  logic         irq;
  int           bad_count;
  int           tests_run;
  int           cyc;
  logic [31:0]  rdat;
  logic         err;

  kid_key_irq dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(req),
    .apb_rsp(apb_rsp), .key_in(key_in), .key_irq(key_irq), .irq(irq));

  kid_key_model keys (.press(press), .key_in(key_in));

  always #20 pclk = ~pclk;

  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  always @(posedge pclk) begin
    cyc++;
    // whole sequence needs well under a thousand cycles
    if (cyc == 5000) begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'h1};
    @(posedge pclk);
    req.penable <= 1'b1;
    // pready ends this wait; only the bench timeout catches a pready that never comes
    do begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    r = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, err);
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rdat, err);
    chk(rdat, exp);
    chk({31'h0000_0000, err}, 32'h0000_0000);
  endtask : rd

  // two flops of sync plus registered output fit well inside eight cycles
  task automatic kirq(input logic exp);
    repeat (8) @(posedge pclk);
    chk({31'h0000_0000, key_irq}, {31'h0000_0000, exp});
  endtask : kirq

  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge pclk);
    chk({31'h0000_0000, irq}, {31'h0000_0000, exp});
  endtask : irq_chk

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    clk_en = 1'b1;
    press = 6'h00;
    req = '0;
    bad_count = 0;
    tests_run = 0;
    cyc = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(KID_OFS_KEY_CONTROL, KID_RST_WORD);
    rd(KID_OFS_KEY_ENABLE, KID_RST_WORD);
    // flags may only be touched while flag use is selected
    wr(KID_OFS_KEY_CONTROL, 32'h0000_0080);
    rd(KID_OFS_KEY_FLAGS, KID_RST_WORD);
    wr(KID_OFS_KEY_CONTROL, 32'h0000_0000);
    rd(KID_OFS_IRQ_STATUS, KID_RST_WORD);
    apb(1'b0, 20'h0_0010, 32'h0000_0000, rdat, err);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    // level mode, falling edge
    wr(KID_OFS_IRQ_ENABLE, 32'h0000_0001);
    wr(KID_OFS_KEY_ENABLE, 32'h0000_0001);
    rd(KID_OFS_KEY_ENABLE, 32'h0000_0001);
    press <= 6'h02;
    kirq(1'b0);
    press <= 6'h03;
    kirq(1'b1);
    press <= 6'h02;
    kirq(1'b0);
    wr(KID_OFS_KEY_ENABLE, 32'h0000_0003);
    kirq(1'b1);
    press <= 6'h00;
    kirq(1'b0);
    // interrupt: raise, mask, clear
    irq_chk(1'b1);
    rd(KID_OFS_IRQ_STATUS, 32'h0000_0001);
    wr(KID_OFS_IRQ_ENABLE, 32'h0000_0000);
    irq_chk(1'b0);
    wr(KID_OFS_IRQ_CLEAR, 32'h0000_0001);
    rd(KID_OFS_IRQ_STATUS, 32'h0000_0000);
    wr(KID_OFS_IRQ_ENABLE, 32'h0000_0001);
    irq_chk(1'b0);
    // rising selection: idle-high keys are already active
    wr(KID_OFS_KEY_CONTROL, 32'h0000_0001);
    rd(KID_OFS_KEY_CONTROL, 32'h0000_0001);
    kirq(1'b1);
    press <= 6'h03;
    kirq(1'b0);
    press <= 6'h00;
    // flag mode, falling edge
    wr(KID_OFS_KEY_CONTROL, 32'h0000_0080);
    kirq(1'b0);
    press <= 6'h01;
    kirq(1'b1);
    rd(KID_OFS_KEY_FLAGS, 32'h0000_0001);
    press <= 6'h03;
    kirq(1'b1);
    rd(KID_OFS_KEY_FLAGS, 32'h0000_0001);
    wr(KID_OFS_KEY_FLAGS, 32'h0000_00ff);
    rd(KID_OFS_KEY_FLAGS, 32'h0000_0001);
    kirq(1'b1);
    wr(KID_OFS_KEY_FLAGS, 32'h0000_00fe);
    rd(KID_OFS_KEY_FLAGS, 32'h0000_0002);
    kirq(1'b1);
    wr(KID_OFS_KEY_FLAGS, 32'h0000_00fd);
    rd(KID_OFS_KEY_FLAGS, 32'h0000_0000);
    kirq(1'b0);
    press <= 6'h00;
    kirq(1'b0);
    rd(KID_OFS_KEY_FLAGS, 32'h0000_0000);
    // both events seen: key request rose, flags loaded
    rd(KID_OFS_IRQ_STATUS, 32'h0000_0003);
    // clock enable low: pins are not even sampled
    clk_en <= 1'b0;
    press <= 6'h01;
    kirq(1'b0);
    clk_en <= 1'b1;
    kirq(1'b1);
    // flag cleared while the key is still held: no second request
    wr(KID_OFS_KEY_FLAGS, 32'h0000_00fe);
    kirq(1'b0);
    press <= 6'h00;
    kirq(1'b0);
    finish_test();
  end

endmodule : kid_key_irq_tb
